/* File: include/lfh_defs.vh */
// Function
// - After a full frame is written the block sends it, then flags completion or error.
// - A ready-for-command frame returning instead of a sent command still sets output-ready.
// - A ready-for-command frame returning after a sent command is checked only in its upper six bits.
// - With talker and listener clear, a stray data frame is retransmitted, maybe forever.
// - Returning ready-for-command and auto-address frames are checked; output-ready only on pass.
// - An incremented returning auto-address frame fails the check and sets frame-not-sent.
// - Returning auto-response frames are loaded with frame-available; data frames follow roles.
// - A returning identify frame is compared ignoring its service-request bit.
// - With controller-active set, data and identify frames update service-request-received.
// - Each data byte write sends that byte with the retained control bits.
// - As listener, received data frames load with frame-available; host retransmits by writing.
// - With talker and listener clear, data retransmits; the end frame loads with frame-available.
// - With controller-active set, an identify frame received in the idle state sets frame-not-sent.
// - Address comparison is skipped with talker or listener set; software compares then.
// - A listener non-controller loads every data frame received in the idle state for the host.
// - Sourced data frames are checked on return; errors show as frame-available or not-sent.
// - Outside analyzer mode, a sent command that returns unchanged, async enable included, is followed automatically by a ready frame.
// - Talker and listener both set is analyzer mode: no checks or retransmission.
`ifndef LFH_DEFS_VH
`define LFH_DEFS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define LFH_OFS_STATUS 8'h00
`define LFH_OFS_CTL_W 8'h04
`define LFH_OFS_DATA_W 8'h08
`define LFH_OFS_CTL_R 8'h0c
`define LFH_OFS_DATA_R 8'h10
`define LFH_OFS_ADDR 8'h14

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define LFH_B_LA 0
`define LFH_B_TA 1
`define LFH_B_CA 2
`define LFH_B_OUTPUT_READY_FLAG 3
`define LFH_B_FRAME_AVAILABLE_FLAG 4
`define LFH_B_FRAME_NOT_SENT_FLAG 5
`define LFH_B_SERVICE_REQUEST_RECEIVED_FLAG 6
`define LFH_B_IFCR 7
`define LFH_ROLE_RST 3'h0
`define LFH_FLAG_RST 5'h00
`define LFH_ADDR_RST 8'h00

// ----------------------------------------
// Frame layout and codes
// ----------------------------------------
`define LFH_FRAME_W 11
`define LFH_CTL_DOE_END 1
`define LFH_CTL_SRQ 0
`define LFH_CTL_CMD 3'h4
`define LFH_CTL_RDY 3'h5
`define LFH_RFC_FRAME 11'h500
`define LFH_IFC_DATA 8'h90
`define LFH_ARG_TAG 2'h1
`define LFH_AAG_TAG 3'h4
`define LFH_LAD_TAG 3'h1
`define LFH_TAD_TAG 3'h2
`define LFH_ADDR_ALL 5'h1f

`endif

/* File: rtl/lfh_loop_frame.v */
// Local design decisions: the Wishbone slave port and the register addresses.
`timescale 1ns/1ns
`include "lfh_defs.vh"
module lfh_loop_frame #(
	parameter FW = `LFH_FRAME_W
) (
	input wire clk_in,
	input wire srst_in,
	input wire wb_cyc_in,
	input wire wb_stb_in,
	input wire wb_we_in,
	input wire [7:0] wb_adr_in,
	input wire [3:0] wb_sel_in,
	input wire [31:0] wb_dat_in,
	output wire [31:0] wb_dat_out,
	output wire wb_ack_out,
	input wire [FW-1:0] loop_rx_frame_in,
	input wire loop_rx_valid_in,
	output wire [FW-1:0] loop_tx_frame_out,
	output wire loop_tx_valid_out,
	input wire loop_tx_ready_in
);

localparam ST_IDLE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_WRFC = 2'h2;

// ----------------------------------------
// State
// ----------------------------------------
reg ack_ff;
reg [31:0] rdat_ff;
reg [2:0] role_ff;
reg [2:0] ctl_w_ff;
reg [7:0] addr_ff;
reg [FW-1:0] rd_frame_ff;
reg [FW-1:0] sent_ff;
reg [FW-1:0] tx_frame_ff;
reg tx_pend_ff;
reg [1:0] st_ff;
reg output_ready_flag_ff, frame_available_flag_ff, frame_not_sent_flag_ff, service_request_received_flag_ff, ifcr_ff;

reg [FW-1:0] nxt_rd_frame;
reg [FW-1:0] nxt_sent;
reg [FW-1:0] nxt_tx_frame;
reg nxt_tx_pend;
reg [1:0] nxt_st;
reg nxt_output_ready_flag, nxt_frame_available_flag, nxt_frame_not_sent_flag, nxt_service_request_received_flag, nxt_ifcr;

// ----------------------------------------
// Bus decode
// ----------------------------------------
wire req = wb_cyc_in & wb_stb_in;
wire wr_go = req & wb_we_in & ack_ff & wb_sel_in[0];
wire wr_stat = wr_go & (wb_adr_in == `LFH_OFS_STATUS);
wire wr_ctl = wr_go & (wb_adr_in == `LFH_OFS_CTL_W);
wire wr_data = wr_go & (wb_adr_in == `LFH_OFS_DATA_W);
wire wr_addr = wr_go & (wb_adr_in == `LFH_OFS_ADDR);

wire la = role_ff[`LFH_B_LA];
wire ta = role_ff[`LFH_B_TA];
wire ca = role_ff[`LFH_B_CA];
wire analyzer = ta & la;
wire idle_role = ~ta & ~la;

// ----------------------------------------
// Frame classification
// ----------------------------------------
wire [2:0] rc = loop_rx_frame_in[FW-1:FW-3];
wire [7:0] rd = loop_rx_frame_in[7:0];
wire [2:0] sc = sent_ff[FW-1:FW-3];
wire [7:0] sd = sent_ff[7:0];
wire r_doe = ~rc[2];
wire r_end = r_doe & rc[`LFH_CTL_DOE_END];
wire r_cmd = (rc == `LFH_CTL_CMD);
wire r_rdy = (rc == `LFH_CTL_RDY);
wire r_idy = rc[2] & rc[1];
localparam [FW-1:0] RFC_FULL = `LFH_RFC_FRAME;
localparam [2:0] SRQ_KEEP = ~(3'h1 << `LFH_CTL_SRQ);
wire r_rfc = (loop_rx_frame_in[FW-1:FW-6] == RFC_FULL[FW-1:FW-6]);
wire r_ifc = r_cmd & (rd == `LFH_IFC_DATA);
wire r_lad = r_cmd & (rd[7:5] == `LFH_LAD_TAG);
wire adr_hit = (rd[4:0] == addr_ff[4:0]) | (rd[4:0] == `LFH_ADDR_ALL);
wire r_mine = r_lad & adr_hit & idle_role;

// ----------------------------------------
// Sent frame classification
// ----------------------------------------
wire s_doe = ~sc[2];
wire s_cmd = (sc == `LFH_CTL_CMD);
wire s_rdy = (sc == `LFH_CTL_RDY);
wire s_idy = sc[2] & sc[1];
wire s_rfc = (sent_ff == RFC_FULL);
wire s_aag = s_rdy & (sd[7:5] == `LFH_AAG_TAG);
wire s_arg = s_rdy & (sd[7:6] == `LFH_ARG_TAG);
wire rx_same = (loop_rx_frame_in == sent_ff);
wire rx_same_idy = ((rc & SRQ_KEEP) == (sc & SRQ_KEEP)) & (rd == sd);

// ----------------------------------------
// Flag clears
// ----------------------------------------
// Flag set wins over a clear in the same cycle
wire tx_acc = tx_pend_ff & loop_tx_ready_in;
wire rd_go = req & ~wb_we_in & ack_ff;
wire rd_data = rd_go & (wb_adr_in == `LFH_OFS_DATA_R);
wire clr_output_ready_flag = (wr_stat & wb_dat_in[`LFH_B_OUTPUT_READY_FLAG]) | wr_data;
wire clr_frame_available_flag = (wr_stat & wb_dat_in[`LFH_B_FRAME_AVAILABLE_FLAG]) | wr_data | rd_data;
wire clr_frame_not_sent_flag = (wr_stat & wb_dat_in[`LFH_B_FRAME_NOT_SENT_FLAG]) | wr_data;
wire clr_service_request_received_flag = wr_stat & wb_dat_in[`LFH_B_SERVICE_REQUEST_RECEIVED_FLAG];
wire clr_ifcr = wr_stat & wb_dat_in[`LFH_B_IFCR];

// ----------------------------------------
// Status word
// ----------------------------------------
wire [31:0] status_word = {24'h0, ifcr_ff, service_request_received_flag_ff, frame_not_sent_flag_ff,
	frame_available_flag_ff, output_ready_flag_ff, role_ff};
reg [31:0] nxt_rdat;

// ----------------------------------------
// Outputs
// ----------------------------------------
assign wb_ack_out = ack_ff;
assign wb_dat_out = rdat_ff;
assign loop_tx_frame_out = tx_frame_ff;
assign loop_tx_valid_out = tx_pend_ff;

// ----------------------------------------
// Frame handling
// ----------------------------------------
// Own frame returns are judged against the copy in sent_ff
always @* begin
	nxt_rd_frame = rd_frame_ff;
	nxt_sent = sent_ff;
	nxt_tx_frame = tx_frame_ff;
	nxt_tx_pend = tx_pend_ff & ~tx_acc;
	nxt_st = st_ff;
	nxt_output_ready_flag = output_ready_flag_ff & ~clr_output_ready_flag;
	nxt_frame_available_flag = frame_available_flag_ff & ~clr_frame_available_flag;
	nxt_frame_not_sent_flag = frame_not_sent_flag_ff & ~clr_frame_not_sent_flag;
	nxt_service_request_received_flag = service_request_received_flag_ff & ~clr_service_request_received_flag;
	nxt_ifcr = ifcr_ff & ~clr_ifcr;
	if (loop_rx_valid_in) begin
		if (ca & (r_doe | r_idy)) begin
			nxt_service_request_received_flag = rc[`LFH_CTL_SRQ];
		end
		if (r_ifc) begin
			nxt_ifcr = 1'b1;
		end
		if (analyzer) begin
			nxt_rd_frame = loop_rx_frame_in;
			nxt_frame_available_flag = 1'b1;
			nxt_st = ST_IDLE;
		end else begin
			case (st_ff)
			ST_WAIT: begin
				if (s_cmd) begin
					if (r_rfc) begin
						nxt_output_ready_flag = 1'b1;
						nxt_st = ST_IDLE;
					end else if (rx_same) begin
						nxt_tx_frame = RFC_FULL;
						nxt_sent = RFC_FULL;
						nxt_tx_pend = 1'b1;
						nxt_st = ST_WRFC;
					end else if (r_doe & idle_role) begin
						nxt_tx_frame = loop_rx_frame_in;
						nxt_tx_pend = 1'b1;
					end else begin
						nxt_frame_not_sent_flag = 1'b1;
						nxt_st = ST_IDLE;
					end
				end else if (s_rfc | s_aag) begin
					if (rx_same) begin
						nxt_output_ready_flag = 1'b1;
						nxt_st = ST_IDLE;
					end else if (r_doe & idle_role) begin
						nxt_tx_frame = loop_rx_frame_in;
						nxt_tx_pend = 1'b1;
					end else begin
						nxt_frame_not_sent_flag = 1'b1;
						nxt_st = ST_IDLE;
					end
				end else if (s_arg) begin
					if (r_rdy) begin
						nxt_rd_frame = loop_rx_frame_in;
						nxt_frame_available_flag = 1'b1;
						nxt_st = ST_IDLE;
					end else if (r_doe & la) begin
						nxt_rd_frame = loop_rx_frame_in;
						nxt_frame_available_flag = 1'b1;
						nxt_st = ST_IDLE;
					end else if (r_doe & idle_role) begin
						nxt_tx_frame = loop_rx_frame_in;
						nxt_tx_pend = 1'b1;
					end else begin
						nxt_frame_not_sent_flag = 1'b1;
						nxt_st = ST_IDLE;
					end
				end else if (s_idy) begin
					if (rx_same_idy) begin
						nxt_output_ready_flag = 1'b1;
					end else begin
						nxt_frame_not_sent_flag = 1'b1;
					end
					nxt_st = ST_IDLE;
				end else if (s_doe) begin
					if (rx_same) begin
						nxt_output_ready_flag = 1'b1;
					end else if (r_doe & la) begin
						nxt_rd_frame = loop_rx_frame_in;
						nxt_frame_available_flag = 1'b1;
					end else begin
						nxt_frame_not_sent_flag = 1'b1;
					end
					nxt_st = ST_IDLE;
				end else begin
					if (rx_same) begin
						nxt_output_ready_flag = 1'b1;
					end else begin
						nxt_frame_not_sent_flag = 1'b1;
					end
					nxt_st = ST_IDLE;
				end
			end
			ST_WRFC: begin
				if (r_rfc) begin
					nxt_output_ready_flag = 1'b1;
					nxt_st = ST_IDLE;
				end else if (r_doe & idle_role) begin
					nxt_tx_frame = loop_rx_frame_in;
					nxt_tx_pend = 1'b1;
				end else begin
					nxt_frame_not_sent_flag = 1'b1;
					nxt_st = ST_IDLE;
				end
			end
			default: begin
				if (r_doe & la) begin
					nxt_rd_frame = loop_rx_frame_in;
					nxt_frame_available_flag = 1'b1;
				end else if (r_end & idle_role) begin
					nxt_rd_frame = loop_rx_frame_in;
					nxt_frame_available_flag = 1'b1;
				end else if (r_idy & ca) begin
					nxt_frame_not_sent_flag = 1'b1;
				end else if (r_mine) begin
					nxt_rd_frame = loop_rx_frame_in;
					nxt_frame_available_flag = 1'b1;
				end else if (~tx_pend_ff) begin
					// Only one frame is held, a second one is dropped
					nxt_tx_frame = loop_rx_frame_in;
					nxt_tx_pend = 1'b1;
				end
			end
			endcase
		end
	end
	// A host write wins over a retransmit in the same cycle
	if (wr_data) begin
		nxt_tx_frame = {ctl_w_ff, wb_dat_in[7:0]};
		nxt_sent = {ctl_w_ff, wb_dat_in[7:0]};
		nxt_tx_pend = 1'b1;
		nxt_st = ST_WAIT;
	end
end

// ----------------------------------------
// Read mux
// ----------------------------------------
always @* begin
	nxt_rdat = 32'h0;
	case (wb_adr_in)
	`LFH_OFS_STATUS: begin
		nxt_rdat = status_word;
	end
	`LFH_OFS_CTL_W: begin
		nxt_rdat = {29'h0, ctl_w_ff};
	end
	`LFH_OFS_CTL_R: begin
		nxt_rdat = {29'h0, rd_frame_ff[FW-1:FW-3]};
	end
	`LFH_OFS_DATA_R: begin
		nxt_rdat = {24'h0, rd_frame_ff[7:0]};
	end
	`LFH_OFS_ADDR: begin
		nxt_rdat = {24'h0, addr_ff};
	end
	default: begin
		nxt_rdat = 32'h0;
	end
	endcase
end

// ----------------------------------------
// Host registers
// ----------------------------------------
always @(posedge clk_in) begin
	if (srst_in) begin
		ack_ff <= 1'b0;
		rdat_ff <= 32'h0;
		role_ff <= `LFH_ROLE_RST;
		ctl_w_ff <= 3'h0;
		addr_ff <= `LFH_ADDR_RST;
	end else begin
		// Writes land on the edge where ack is seen high
		ack_ff <= req & ~ack_ff;
		if (req & ~ack_ff) begin
			rdat_ff <= nxt_rdat;
		end
		if (wr_stat) begin
			role_ff <= wb_dat_in[`LFH_B_CA:`LFH_B_LA];
		end
		if (wr_ctl) begin
			ctl_w_ff <= wb_dat_in[2:0];
		end
		if (wr_addr) begin
			addr_ff <= wb_dat_in[7:0];
		end
	end
end

// ----------------------------------------
// Frame registers
// ----------------------------------------
always @(posedge clk_in) begin
	if (srst_in) begin
		rd_frame_ff <= {FW{1'b0}};
		sent_ff <= {FW{1'b0}};
		tx_frame_ff <= {FW{1'b0}};
		tx_pend_ff <= 1'b0;
		st_ff <= ST_IDLE;
		{output_ready_flag_ff, frame_available_flag_ff, frame_not_sent_flag_ff, service_request_received_flag_ff, ifcr_ff} <= `LFH_FLAG_RST;
	end else begin
		rd_frame_ff <= nxt_rd_frame;
		sent_ff <= nxt_sent;
		tx_frame_ff <= nxt_tx_frame;
		tx_pend_ff <= nxt_tx_pend;
		st_ff <= nxt_st;
		output_ready_flag_ff <= nxt_output_ready_flag;
		frame_available_flag_ff <= nxt_frame_available_flag;
		frame_not_sent_flag_ff <= nxt_frame_not_sent_flag;
		service_request_received_flag_ff <= nxt_service_request_received_flag;
		ifcr_ff <= nxt_ifcr;
	end
end

endmodule

/* File: tb/lfh_props.sv */
`timescale 1ns/1ns
module lfh_props #(parameter FW = 11) (input wire clk_in, srst_in,
	wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out, loop_tx_valid_out,
	loop_tx_ready_in, input wire [7:0] wb_adr_in,
	input wire [31:0] wb_dat_in, input wire [FW-1:0] loop_tx_frame_out);
	logic [10:0] exp_ff;
	wire wr = wb_ack_out && wb_we_in;
	wire txa = loop_tx_valid_out && loop_tx_ready_in;
	wire cmd = txa && loop_tx_frame_out[10:8] == 3'h4;
	// Frame the block ought to source after a data byte write
	always @(posedge clk_in) begin
		if (wr && wb_adr_in == 8'h04) exp_ff[10:8] <= wb_dat_in[2:0];
		if (wr && wb_adr_in == 8'h08) exp_ff[7:0] <= wb_dat_in[7:0];
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	AST_ACK_ONE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack held");
	AST_ACK_REQ: assert property (wb_ack_out |-> wb_cyc_in && wb_stb_in)
		else $error("ack without request");
	AST_ACK_SOON: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out
		|-> ##[1:8] wb_ack_out) else $error("no ack");
	AST_TX_HOLD: assert property (loop_tx_valid_out && !loop_tx_ready_in
		|=> loop_tx_valid_out && $stable(loop_tx_frame_out)) else $error("tx");
	AST_TX_FRAME: assert property (wr && wb_adr_in == 8'h08
		|-> ##[2:64] txa && loop_tx_frame_out == exp_ff) else $error("frame");
	AST_TX_DROP: assert property (txa |=> !loop_tx_valid_out)
		else $error("tx not dropped");
	AST_RFC_AFTER: assert property (cmd |-> ##[1:32]
		txa && loop_tx_frame_out == 11'h500) else $error("no ready frame");
	AST_RST_IDLE: assert property (disable iff (1'b0) srst_in |=>
		!loop_tx_valid_out && !wb_ack_out) else $error("reset");
endmodule

/* File: tb/lfh_peer.sv */
`timescale 1ns/1ns
module lfh_peer (input wire clk_in, vld_in, inc_in,
	input wire [10:0] tx_in, output logic rdy_out = 0,
	output logic rxv_out = 0, output logic [10:0] rx_out = 11'h2aa);
	always @(posedge clk_in) begin
		rdy_out <= vld_in && !rdy_out;
		rxv_out <= vld_in && rdy_out;
		rx_out <= (vld_in && rdy_out) ? tx_in + inc_in : ~rx_out;
	end
endmodule

/* File: tb/lfh_loop_frame_test.sv */
`timescale 1ns/1ns
module lfh_loop_frame_test;
	logic clk_in = 0, srst_in = 1, cyc = 0, we = 0, inc = 0;
	logic [7:0] adr = 0;
	logic [31:0] dw = 0, dr, q;
	logic [10:0] rxf, txf, seen;
	wire ack, rdy, rxv, txv;
	int errors = 0, num_checks = 0;
	initial forever #2 clk_in = ~clk_in;
	lfh_loop_frame i_lfh_loop_frame (.clk_in, .srst_in, .wb_cyc_in(cyc),
		.wb_stb_in(cyc), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'hf),
		.wb_dat_in(dw), .wb_dat_out(dr), .wb_ack_out(ack),
		.loop_rx_frame_in(rxf), .loop_rx_valid_in(rxv),
		.loop_tx_frame_out(txf), .loop_tx_valid_out(txv),
		.loop_tx_ready_in(rdy));
	lfh_peer i_lfh_peer (.clk_in, .vld_in(txv), .inc_in(inc), .tx_in(txf),
		.rdy_out(rdy), .rxv_out(rxv), .rx_out(rxf));
	always @(posedge clk_in) if (txv && rdy) seen <= txf;
	task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk_in) {cyc, we, adr, dw} <= {1'b1, w, a, d};
		repeat (50) begin @(posedge clk_in); if (ack === 1'b1) break; end
		if (ack !== 1'b1) begin
			errors++;
			$display("BAD %0t no ack", $time);
		end
		q = dr;
		cyc <= 0;
	endtask
	task chk(input logic [31:0] g, e);
		num_checks++;
		if (g !== e) begin errors++; $display("BAD %0t %h %h", $time, g, e); end
	endtask
	task flag(input int b);
		repeat (40) begin bus(8'h00, 0, 0); if (q[b] === 1'b1) break; end
		chk(q[b], 1);
	endtask
	task t_data;
		bus(8'h00, 1, 32'h4);
		bus(8'h04, 1, 0);
		bus(8'h08, 1, 32'h5a);
		flag(3);
		chk(seen, 11'h05a);
		bus(8'h08, 1, 32'ha5);
		flag(3);
		chk(seen, 11'h0a5);
	endtask
	task t_cmd;
		bus(8'h04, 1, 32'h4);
		bus(8'h08, 1, 32'h3f);
		flag(3);
		chk(seen, 11'h500);
	endtask
	task t_aag;
		inc <= 1;
		bus(8'h04, 1, 32'h5);
		bus(8'h08, 1, 32'h80);
		flag(5);
		inc <= 0;
	endtask
	task t_idy;
		bus(8'h04, 1, 32'h7);
		bus(8'h08, 1, 0);
		flag(3);
		flag(6);
	endtask
	task t_roles;
		bus(8'h00, 1, 32'h1);
		bus(8'h00, 0, 0);
		chk(q[2:0], 3'h1);
		bus(8'h00, 1, 32'h2);
		bus(8'h00, 0, 0);
		chk(q[2:0], 3'h2);
	endtask
	task t_ana;
		bus(8'h00, 1, 32'h3);
		bus(8'h04, 1, 0);
		inc <= 1;
		bus(8'h08, 1, 32'h10);
		flag(4);
		bus(8'h10, 0, 0);
		chk(q, 32'h11);
		bus(8'h00, 0, 0);
		chk(q[4], 0);
		inc <= 0;
	endtask
	task end_of_test;
		$display("errors %0d checks %0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	initial begin #40000; errors++; end_of_test; end
	initial begin
		repeat (5) @(posedge clk_in);
		srst_in <= 0;
		t_data;
		t_cmd;
		t_aag;
		t_idy;
		t_roles;
		t_ana;
		end_of_test;
	end
endmodule
bind lfh_loop_frame lfh_props #(.FW(FW)) i_lfh_props (.*);
